// ### hdl/erb_pkg.sv
// Purpose: Shared constants and carriers for the embedded RAM block
// Assumes: 32-bit AXI4-Lite register bus, 4,096-bit storage array
// Notes:   Offsets are byte addresses of aligned words
package erb_pkg;
    localparam int          MEM_ROWS      = 256;
    localparam int          ROW_W         = 16;
    localparam int          ADDR_W        = 11;
    localparam int          ROW_AW        = 8;
    // Shapes: words x bits
    localparam logic [1:0]  SHAPE_256X16  = 2'h0;
    localparam logic [1:0]  SHAPE_512X8   = 2'h1;
    localparam logic [1:0]  SHAPE_1024X4  = 2'h2;
    localparam logic [1:0]  SHAPE_2048X2  = 2'h3;
    // Register offsets
    localparam logic [7:0]  OFS_CFG       = 8'h00;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    localparam logic [7:0]  OFS_LOAD_ADDR = 8'h08;
    localparam logic [7:0]  OFS_LOAD_DATA = 8'h0c;
    // Configuration field positions
    localparam int          CFG_SHAPE_LSB = 0;
    localparam int          CFG_DUAL      = 2;
    localparam int          CFG_ROM       = 3;
    localparam int          CFG_SPLIT     = 4;
    localparam int          CFG_REG_LSB   = 5;
    localparam int          CFG_W         = 11;
    localparam logic [10:0] CFG_RESET     = 11'h004;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // Per-path register enables
    typedef struct packed {
        logic re;
        logic raddr;
        logic we;
        logic waddr;
        logic dout;
        logic din;
    } erb_regsel_t;

    typedef struct packed {
        erb_regsel_t regs;
        logic        split;
        logic        rom;
        logic        dual;
        logic [1:0]  shape;
    } erb_cfg_t;

    // Fabric-side inputs, moved through the synchroniser as one word
    typedef struct packed {
        logic              wclk;
        logic              rclk;
        logic              wce;
        logic              rce;
        logic              we;
        logic              re;
        logic [ADDR_W-1:0] waddr;
        logic [ADDR_W-1:0] raddr;
        logic [ROW_W-1:0]  din;
    } erb_fab_t;
endpackage : erb_pkg

// ### hdl/erb_ram.sv
// Purpose: Embedded RAM block with shapes, ROM table use, optional path registers
// Assumes: Fabric clocks arrive as levels sampled by mclk (much faster than them)
// Notes:   Configuration and table loading through AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - RAM shapes 256x16, 512x8, 1024x4 or 2048x2 are selectable.
// - ROM use: table loaded at configuration, read as lookup, 8 in 16 out.
// - Single-port mode and dual-port mode with separate write and read sections.
// - In dual-port mode each section runs on its own clock.
// - Each section has its own synchronous clock enable.
// - Alternative: one clock for input registers, another for output register.
// - Path, output and synchroniser registers clear asynchronously by local, global or chip reset; configuration and bus registers by chip reset only.
// - Writes synchronous with an internally generated write pulse.
// - Data in, data out, addresses and enables each have an optional register.
module erb_ram (
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    input  wire logic                   clr_local,
    input  wire logic                   clr_global,
    input  wire erb_pkg::erb_fab_t      fab_in,
    output logic [erb_pkg::ROW_W-1:0]   rd_data,
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);
    import erb_pkg::*;

    // Selects the row holding a word, and the lane inside it, for a shape
    function automatic logic [ROW_AW-1:0] row_of(input logic [ADDR_W-1:0] a, input logic [1:0] s);
        row_of = ROW_AW'(a >> s);
    endfunction : row_of
    function automatic logic [ROW_W-1:0] lane_mask(input logic [ADDR_W-1:0] a, input logic [1:0] s);
        logic [ROW_W-1:0] m;
        logic [3:0]       sh;
        // Lane width is 16 >> shape bits, so the mask is that many ones
        m = ROW_W'((17'h1 << (5'h10 >> s)) - 17'h1);
        sh = 4'((a & ADDR_W'((11'h1 << s) - 11'h1)) << (3'h4 - 3'(s)));
        lane_mask = m << sh;
    endfunction : lane_mask
    function automatic logic [3:0] lane_sh(input logic [ADDR_W-1:0] a, input logic [1:0] s);
        lane_sh = 4'((a & ADDR_W'((11'h1 << s) - 11'h1)) << (3'h4 - 3'(s)));
    endfunction : lane_sh

    logic [ROW_W-1:0]   mem [MEM_ROWS];
    erb_cfg_t           cfg_r;
    logic [ADDR_W-1:0]  load_addr_r;
    logic [15:0]        wr_count_r;
    erb_fab_t           sync1_r, sync2_r;
    logic               wclk_d_r, rclk_d_r;
    // Path registers
    logic [ADDR_W-1:0]  waddr_r, raddr_r;
    logic               we_r, re_r;
    logic [ROW_W-1:0]   din_r, dout_r;

    // Any of the three clears empties every pipeline register; configuration is kept
    // so that a fabric clear does not lose the programmed mode.
    wire                clr_n = rstn & ~clr_local & ~clr_global;

    wire                wclk_evt = sync2_r.wclk & ~wclk_d_r;
    wire                rclk_evt = sync2_r.rclk & ~rclk_d_r;
    // Write section event; also the input-register clock in split arrangement
    wire                in_tick  = wclk_evt & sync2_r.wce;
    // Read side: own clock in dual-port, write clock in single-port
    wire                rd_evt   = cfg_r.dual ? rclk_evt : wclk_evt;
    wire                rd_ce    = cfg_r.dual ? sync2_r.rce : sync2_r.wce;
    wire                out_tick = rd_evt & rd_ce;
    // Split arrangement: all input registers follow the write clock
    wire                rin_tick = cfg_r.split ? in_tick : out_tick;

    // Path selection: register output when enabled, else the sampled pin
    wire [ADDR_W-1:0]   waddr_e  = cfg_r.regs.waddr ? waddr_r : sync2_r.waddr;
    wire                we_e     = cfg_r.regs.we ? we_r : sync2_r.we;
    wire [ROW_W-1:0]    din_e    = cfg_r.regs.din ? din_r : sync2_r.din;
    wire [ADDR_W-1:0]   raddr_p  = cfg_r.dual ? sync2_r.raddr : sync2_r.waddr;
    wire [ADDR_W-1:0]   raddr_e  = cfg_r.regs.raddr ? raddr_r : raddr_p;
    wire                re_e     = cfg_r.regs.re ? re_r : sync2_r.re;
    // ROM use forbids fabric writes; writes happen once per write event only
    wire                wr_pulse = in_tick & we_e & ~cfg_r.rom;
    wire [ROW_AW-1:0]   wrow     = row_of(waddr_e, cfg_r.shape);
    wire [ROW_W-1:0]    wmask    = lane_mask(waddr_e, cfg_r.shape);
    wire [ROW_W-1:0]    wdata    = din_e << lane_sh(waddr_e, cfg_r.shape);
    wire [ROW_W-1:0]    rword    = mem[row_of(raddr_e, cfg_r.shape)] >> lane_sh(raddr_e, cfg_r.shape);
    wire [ROW_W-1:0]    rvalue   = rword & (lane_mask(11'h0, cfg_r.shape));

    // AXI decode
    logic               aw_held_r, w_held_r;
    logic [7:0]         awaddr_r;
    logic [31:0]        wdata_r;
    wire                aw_take  = s_axi_awvalid & s_axi_awready;
    wire                w_take   = s_axi_wvalid & s_axi_wready;
    wire                wr_go    = aw_held_r & w_held_r & ~s_axi_bvalid;
    wire                wr_cfg   = wr_go & (awaddr_r == OFS_CFG);
    wire                wr_ladr  = wr_go & (awaddr_r == OFS_LOAD_ADDR);
    wire                wr_ldat  = wr_go & (awaddr_r == OFS_LOAD_DATA);
    wire                wr_ok    = wr_cfg | wr_ladr | wr_ldat | (wr_go & (awaddr_r == OFS_STATUS));
    wire                ar_take  = s_axi_arvalid & s_axi_arready;
    wire                rd_cfg   = s_axi_araddr == OFS_CFG;
    wire                rd_stat  = s_axi_araddr == OFS_STATUS;
    wire                rd_ladr  = s_axi_araddr == OFS_LOAD_ADDR;
    wire                rd_ldat  = s_axi_araddr == OFS_LOAD_DATA;
    wire                rd_ok    = rd_cfg | rd_stat | rd_ladr | rd_ldat;
    wire [31:0]         rd_mux   = rd_cfg  ? 32'(cfg_r) :
                                   rd_stat ? {wr_count_r, rd_data} :
                                   rd_ladr ? 32'(load_addr_r) :
                                   rd_ldat ? 32'(mem[load_addr_r[ROW_AW-1:0]]) : 32'h0;

    // Input synchroniser; clocks and their data stay aligned through it
    always_ff @(posedge mclk or negedge clr_n) begin
        if (!clr_n) begin
            sync1_r  <= '0;
            sync2_r  <= '0;
            wclk_d_r <= 1'b0;
            rclk_d_r <= 1'b0;
        end else begin
            sync1_r  <= fab_in;
            sync2_r  <= sync1_r;
            wclk_d_r <= sync2_r.wclk;
            rclk_d_r <= sync2_r.rclk;
        end
    end

    always_ff @(posedge mclk or negedge clr_n) begin
        if (!clr_n) begin
            waddr_r <= '0;
            we_r    <= 1'b0;
            din_r   <= '0;
        end else if (in_tick) begin
            waddr_r <= sync2_r.waddr;
            we_r    <= sync2_r.we;
            din_r   <= sync2_r.din;
        end
    end

    always_ff @(posedge mclk or negedge clr_n) begin
        if (!clr_n) begin
            raddr_r <= '0;
            re_r    <= 1'b0;
        end else if (rin_tick) begin
            raddr_r <= raddr_p;
            re_r    <= sync2_r.re;
        end
    end

    // Output register moves only on an enabled read-clock event
    always_ff @(posedge mclk or negedge clr_n) begin
        if (!clr_n) begin
            dout_r  <= '0;
        end else if (out_tick && re_e) begin
            dout_r  <= rvalue;
        end
    end

    // Unregistered output still leaves through a flop, one mclk behind the array
    always_ff @(posedge mclk or negedge clr_n) begin
        if (!clr_n) begin
            rd_data <= '0;
        end else if (cfg_r.regs.dout) begin
            rd_data <= out_tick && re_e ? rvalue : dout_r;
        end else if (re_e) begin
            rd_data <= rvalue;
        end
    end

    // Storage; the table load port and the fabric write share one process
    always_ff @(posedge mclk) begin
        if (wr_ldat && cfg_r.rom) begin
            mem[load_addr_r[ROW_AW-1:0]] <= wdata_r[ROW_W-1:0];
        end else if (wr_pulse) begin
            mem[wrow] <= (mem[wrow] & ~wmask) | (wdata & wmask);
        end
    end

    always_ff @(posedge mclk or negedge clr_n) begin
        if (!clr_n) begin
            wr_count_r <= '0;
        end else if (wr_pulse) begin
            wr_count_r <= wr_count_r + 16'h1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cfg_r       <= erb_cfg_t'(CFG_RESET);
            load_addr_r <= '0;
        end else begin
            if (wr_cfg) begin
                cfg_r <= erb_cfg_t'(wdata_r[CFG_W-1:0]);
            end
            // Sequential loading: each data write in ROM use steps the address
            if (wr_ladr) begin
                load_addr_r <= wdata_r[ADDR_W-1:0];
            end else if (wr_ldat && cfg_r.rom) begin
                load_addr_r <= load_addr_r + 11'h1;
            end
        end
    end

    // AXI4-Lite slave: address and data taken in either order, answer after both
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_r     <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_held_r     <= 1'b1;
                wdata_r      <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule : erb_ram
`default_nettype wire

// ### dv/erb_ram_assertions.sv
// Purpose: Port-level checks for the embedded RAM block
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Attached by bind from the bench top
`timescale 1ns/100ps
`default_nettype none
module erb_ram_assertions (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        clr_local,
    input wire logic        clr_global,
    input wire logic [15:0] rd_data,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    import erb_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_b_after_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_b_after_both: assert property (p_b_after_both) else $error("write answer late");
    property p_b_stands;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_stands: assert property (p_b_stands) else $error("write answer dropped");
    property p_b_blocks;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_blocks: assert property (p_b_blocks) else $error("write taken while busy");
    property p_b_release;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_release: assert property (p_b_release) else $error("write answer repeated");
    property p_r_next;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_next: assert property (p_r_next) else $error("read answer late");
    property p_r_stands;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
    endproperty
    a_r_stands: assert property (p_r_stands) else $error("read answer changed");
    property p_r_blocks;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_r_blocks: assert property (p_r_blocks) else $error("read taken while busy");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h10 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
    property p_clear;
        clr_local || clr_global |-> rd_data == 16'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("output not cleared");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_global: cover property (clr_global);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : erb_ram_assertions
`default_nettype wire

// ### dv/erb_fabric_model.sv
// Purpose: User logic that drives the fabric side of the RAM block
// Assumes: Fabric clocks are slow levels, high for 4 mclk and low for at least 8 mclk
// Notes:   Reads and writes never overlap, so no undefined collisions
`timescale 1ns/100ps
`default_nettype none
module erb_fabric_model (
    input  wire logic         mclk,
    output var erb_pkg::erb_fab_t fab
);
    import erb_pkg::*;
    initial fab = '0;
    // One block only: two-port use runs in this block; wider and deeper memories are built from several
    // Payload set 3 mclk ahead and held past the edge
    task automatic pulse(input logic is_rd);
        repeat (3) @(posedge mclk);
        if (is_rd) fab.rclk <= 1'b1;
        else fab.wclk <= 1'b1;
        repeat (4) @(posedge mclk);
        fab.rclk <= 1'b0;
        fab.wclk <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : pulse
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [ROW_W-1:0] d, input logic ce);
        @(posedge mclk);
        fab.waddr <= a;
        fab.din   <= d;
        fab.we    <= 1'b1;
        fab.wce   <= ce;
        pulse(1'b0);
        fab.we  <= 1'b0;
        // Hold over: show other data so stale capture is caught
        fab.din <= ~d;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic ce);
        @(posedge mclk);
        fab.raddr <= a;
        fab.re    <= 1'b1;
        fab.rce   <= ce;
        pulse(1'b1);
    endtask : rd
endmodule : erb_fabric_model
`default_nettype wire

// ### dv/dual_port_embedded_ram_tb_top.sv
// Purpose: Self-checking bench for the embedded RAM block
// Assumes: Fabric driven by the partner model, registers over AXI4-Lite
// Notes:   Drivers queue expectations, one monitor compares them
`timescale 1ns/100ps
`default_nettype none
module dual_port_embedded_ram_tb_top;
    import erb_pkg::*;
    logic mclk, rstn, clr_local, clr_global, rd_chk;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, samples_checked, mismatches, cycles;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] rd_data, d;
    logic [ADDR_W-1:0] a;
    logic [35:0] exp_q[$];
    erb_fab_t fab;
    erb_fabric_model fab_u (.mclk(mclk), .fab(fab));
    erb_ram dut_u (.mclk(mclk), .rstn(rstn), .clr_local(clr_local), .clr_global(clr_global),
        .fab_in(fab), .rd_data(rd_data), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    task automatic check(input logic [35:0] act);
        logic [35:0] e;
        e = 'x;
        samples_checked = samples_checked + 1;
        if (exp_q.size() > 0) e = exp_q.pop_front();
        if (act !== e) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t got %h want %h", $time, act, e);
        end
    endtask : check
    always @(posedge mclk) begin
        if (s_axi_bvalid && s_axi_bready) check({2'h1, s_axi_bresp, 32'h0});
        if (s_axi_rvalid && s_axi_rready) check({2'h2, s_axi_rresp, s_axi_rdata});
        if (rd_chk) check({2'h3, 2'h0, 16'h0, rd_data});
        cycles = cycles + 1;
        if (cycles == 32'd8000) begin
            mismatches = mismatches + 1;
            complete_run();
        end
    end
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] v, input logic [1:0] r);
        exp_q.push_back({2'h1, r, 32'h0});
        s_axi_awaddr  <= ad;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] ad, input logic [1:0] r, input logic [31:0] v);
        exp_q.push_back({2'h2, r, v});
        s_axi_araddr  <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask : axi_rd
    task automatic expect_rd(input logic [15:0] v);
        exp_q.push_back({2'h3, 2'h0, 16'h0, v});
        rd_chk <= 1'b1;
        @(posedge mclk);
        rd_chk <= 1'b0;
    endtask : expect_rd
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        {rstn, clr_local, clr_global, rd_chk, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {samples_checked, mismatches, cycles} = '0;
        s_axi_wstrb = 4'hf;
        seed = 32'h45d7;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        axi_rd(OFS_CFG, RESP_OKAY, 32'(CFG_RESET));
        axi_rd(8'h20, RESP_SLVERR, 32'h0);
        axi_wr(8'h20, rnd(), RESP_SLVERR);
        for (int s = 0; s < 4; s++) begin
            axi_wr(OFS_CFG, 32'h4 | s, RESP_OKAY);
            a = 11'(rnd() & ((32'h100 << s) - 1));
            d = 16'(rnd());
            fab_u.wr(a, d, 1'b1);
            fab_u.wr(a ^ 11'h1, ~d, 1'b1);
            fab_u.rd(a, 1'b1);
            expect_rd(d & 16'((32'h1 << (16 >> s)) - 1));
        end
        // Registered output, so a stalled read must leave the word alone
        axi_wr(OFS_CFG, 32'h44, RESP_OKAY);
        d = 16'(rnd());
        fab_u.wr(11'h10, d, 1'b1);
        fab_u.wr(11'h10, ~d, 1'b0);
        fab_u.rd(11'h10, 1'b1);
        expect_rd(d);
        fab_u.wr(11'h11, ~d, 1'b1);
        fab_u.rd(11'h11, 1'b0);
        expect_rd(d);
        for (int k = 0; k < 2; k++) begin
            if (k == 0) clr_local <= 1'b1;
            else clr_global <= 1'b1;
            @(posedge mclk);
            expect_rd(16'h0);
            clr_local  <= 1'b0;
            clr_global <= 1'b0;
            fab_u.rd(11'h10, 1'b1);
            expect_rd(d);
        end
        for (int k = 0; k < 2; k++) begin
            axi_wr(OFS_CFG, (k == 1) ? 32'h24 : 32'h84, RESP_OKAY);
            d = 16'(rnd());
            fab_u.wr(11'h20, d, 1'b1);
            fab_u.wr(11'h21, ~d, 1'b1);
            axi_wr(OFS_CFG, 32'h4, RESP_OKAY);
            fab_u.rd((k == 1) ? 11'h21 : 11'h20, 1'b1);
            expect_rd((k == 1) ? d : ~d);
        end
        // Single port reads at the write address, whatever raddr shows
        axi_wr(OFS_CFG, 32'h0, RESP_OKAY);
        d = 16'(rnd());
        fab_u.wr(11'h30, d, 1'b1);
        fab_u.rd(11'h35, 1'b1);
        expect_rd(d);
        axi_wr(OFS_CFG, 32'hc, RESP_OKAY);
        axi_wr(OFS_LOAD_ADDR, 32'h7f, RESP_OKAY);
        d = 16'(rnd());
        axi_wr(OFS_LOAD_DATA, {16'h0, d}, RESP_OKAY);
        fab_u.wr(11'h7f, ~d, 1'b1);
        fab_u.rd(11'h7f, 1'b1);
        expect_rd(d);
        axi_rd(OFS_CFG, RESP_OKAY, 32'hc);
        // Split clocking: read address register moves only on write events
        axi_wr(OFS_CFG, 32'h254, RESP_OKAY);
        d = 16'(rnd());
        fab_u.rd(11'h40, 1'b0);
        fab_u.wr(11'h40, d, 1'b1);
        fab_u.rd(11'h41, 1'b1);
        expect_rd(d);
        repeat (4) @(posedge mclk);
        complete_run();
    end
endmodule : dual_port_embedded_ram_tb_top
bind erb_ram erb_ram_assertions chk_u (.mclk(mclk), .rstn(rstn), .clr_local(clr_local),
    .clr_global(clr_global), .rd_data(rd_data), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
`default_nettype wire
